//--- pkg/lpwc_pkg.sv
package lpwc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINES  = 19;
  localparam int GPIO_LINES = 16;
  localparam int NUM_PORTS  = 4;
  localparam int PORT_SEL_W = 2;
  localparam int SYNC_W     = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_IMASK = 8'h08;
  localparam logic [7:0] OFS_EMASK = 8'h0c;
  localparam logic [7:0] OFS_RISE  = 8'h10;
  localparam logic [7:0] OFS_FALL  = 8'h14;
  localparam logic [7:0] OFS_PEND  = 8'h18;
  localparam logic [7:0] OFS_PSEL  = 8'h1c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_MODE_LO   = 0;
  localparam int STAT_PVD_OUT   = 2;
  localparam int STAT_STBY_FLAG = 3;
  localparam int LINE_SUPPLY    = 16;
  localparam int LINE_RTC       = 17;
  localparam int LINE_SPARE     = 18;

  localparam int SY_SUPPLY_OK  = 0;
  localparam int SY_SUPPLY_LOW = 1;
  localparam int SY_PIN_N      = 2;
  localparam int SY_WAKE_PIN   = 3;
  localparam int SY_WATCHDOG   = 4;
  localparam int SY_RTC        = 5;

  localparam logic [6:0]  CTRL_RST = 7'h00;
  localparam logic [18:0] LINE_RST = 19'h00000;
  localparam logic [31:0] PSEL_RST = 32'h00000000;
  localparam logic [5:0]  SYNC_RST = 6'h04;

  localparam logic [1:0] MODE_CODE_RUN   = 2'h0;
  localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CODE_STOP  = 2'h2;
  localparam logic [1:0] MODE_CODE_STBY  = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_STOP,
    MODE_STANDBY
  } lpwc_mode_t;

  typedef struct packed {
    logic [2:0] pvd_level;
    logic       pvd_en;
    logic       lp_reg_sel;
    logic       standby_sel;
    logic       deep_sel;
  } lpwc_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } lpwc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lpwc_apb_rsp_t;

  typedef struct packed {
    logic core_halt;
    logic core_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic internal_fast_rc_en;
    logic external_fast_oscillator_en;
    logic main_regulator_mode;
    logic low_power_regulator_mode;
    logic regulator_off;
    logic lowspeed_clk_en;
  } lpwc_pwr_t;

endpackage

//--- rtl/lpwc_edge_det.sv
`timescale 1ns/1ns
`default_nettype none

module lpwc_edge_det
  import lpwc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic line_i,
  input  wire logic rise_en_i,
  input  wire logic fall_en_i,
  output logic      hit_o
);

  logic rise_cap_q;
  logic fall_cap_q;
  logic clr_q;
  logic meta_q;
  logic sync_q;
  logic seen_q;
  logic hit_q;
  wire  cap_rst;
  wire  cap_any;

  // ----------------------------------------------------------------
  // capture on the line's own edge
  // ----------------------------------------------------------------
  // the line itself clocks the capture flop, so a pulse far shorter
  // than a bus clock still leaves a mark; limitation: an edge that
  // falls inside the few-cycle clear window is not seen
  assign cap_rst = reset_i | clr_q;
  assign cap_any = rise_cap_q | fall_cap_q;

  always_ff @(posedge line_i or posedge cap_rst) begin
    if (cap_rst) begin
      rise_cap_q <= 1'b0;
    end else if (rise_en_i) begin
      rise_cap_q <= 1'b1;
    end
  end

  always_ff @(negedge line_i or posedge cap_rst) begin
    if (cap_rst) begin
      fall_cap_q <= 1'b0;
    end else if (fall_en_i) begin
      fall_cap_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // bring the mark into the bus clock and release the capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      seen_q <= 1'b0;
      clr_q  <= 1'b0;
      hit_q  <= 1'b0;
    end else begin
      meta_q <= cap_any;
      sync_q <= meta_q;
      seen_q <= sync_q;
      clr_q  <= sync_q;
      hit_q  <= sync_q & ~seen_q;
    end
  end

  assign hit_o = hit_q;

  property p_hit_single;
    @(posedge clk_i) disable iff (reset_i)
    hit_q |=> !hit_q;
  endproperty
  a_hit_single: assert property (p_hit_single) else $error("edge hit longer than one cycle");

endmodule

`default_nettype wire

//--- rtl/lpwc_power_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - sleep stops core only, peripherals keep clocks
// - any peripheral interrupt or event ends sleep
// - stop gates core clocks, pll, oscillators
// - stop keeps all register contents
// - stop regulator mode chosen by software
// - any edge line wakes from stop
// - standby switches regulator and oscillators off
// - standby exit loses all but backup state
// - standby exits on pin, watchdog, wake, alarm
// - low-speed clocks keep running in stop, standby
// - regulator main in run, main or low in stop, off standby
// - every reset leaves regulator enabled
// - hold reset while supply below threshold
// - detector interrupt on falling, rising or both
// - detector inactive until software enables it
// - nineteen edge lines raise interrupt or event
// - per line edge select and mask
// - pending bit holds request until handled
// - capture pulses shorter than a bus clock
// - gpio pins route onto sixteen lines

module lpwc_power_ctrl
  import lpwc_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire lpwc_apb_req_t             apb_i,
  output var  lpwc_apb_rsp_t             apb_o,
  input  wire logic                      core_sleep_req_i,
  input  wire logic                      periph_irq_i,
  input  wire logic [NUM_PORTS-1:0][15:0] gpio_i,
  input  wire logic                      rtc_alarm_i,
  input  wire logic                      spare_line_i,
  input  wire logic                      supply_ok_i,
  input  wire logic                      supply_below_i,
  input  wire logic                      reset_pin_n_i,
  input  wire logic                      wake_pin_i,
  input  wire logic                      watchdog_reset_i,
  output var  lpwc_pwr_t                 pwr_o,
  output logic                           sys_reset_o,
  output logic                           pvd_en_o,
  output logic [2:0]                     pvd_level_o,
  output logic [NUM_LINES-1:0]           line_irq_o,
  output logic [NUM_LINES-1:0]           line_event_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lpwc_mode_t           state_q;
  lpwc_mode_t           state_d;
  lpwc_pwr_t            pwr_q;
  lpwc_pwr_t            pwr_d;
  lpwc_ctrl_t           ctrl_q;
  logic [NUM_LINES-1:0] imask_q;
  logic [NUM_LINES-1:0] emask_q;
  logic [NUM_LINES-1:0] rise_q;
  logic [NUM_LINES-1:0] fall_q;
  logic [NUM_LINES-1:0] pend_q;
  logic [NUM_LINES-1:0] pend_d;
  logic [NUM_LINES-1:0] irq_q;
  logic [NUM_LINES-1:0] event_q;
  logic [31:0]          psel_q;
  logic [SYNC_W-1:0]    meta_q;
  logic [SYNC_W-1:0]    sync_q;
  logic                 wake_prev_q;
  logic                 pvd_out_q;
  logic                 stby_flag_q;
  logic                 sys_reset_q;
  logic                 ready_q;
  logic                 err_q;
  logic [31:0]          rdata_q;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [SYNC_W-1:0] raw_in;

  assign raw_in = {rtc_alarm_i, watchdog_reset_i, wake_pin_i,
                   reset_pin_n_i, supply_below_i, supply_ok_i};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc      = apb_i.psel & apb_i.penable;
  wire first    = acc & ~ready_q;
  wire wr_en    = acc & ready_q & apb_i.pwrite;
  wire sel_ctrl = apb_i.paddr == OFS_CTRL;
  wire sel_stat = apb_i.paddr == OFS_STAT;
  wire sel_imsk = apb_i.paddr == OFS_IMASK;
  wire sel_emsk = apb_i.paddr == OFS_EMASK;
  wire sel_rise = apb_i.paddr == OFS_RISE;
  wire sel_fall = apb_i.paddr == OFS_FALL;
  wire sel_pend = apb_i.paddr == OFS_PEND;
  wire sel_psel = apb_i.paddr == OFS_PSEL;
  wire addr_ok  = sel_ctrl | sel_stat | sel_imsk | sel_emsk |
                  sel_rise | sel_fall | sel_pend | sel_psel;

  wire [NUM_LINES-1:0] wdata_lines = apb_i.pwdata[NUM_LINES-1:0];
  wire [1:0]           mode_code;

  assign mode_code = (state_q == MODE_SLEEP)   ? MODE_CODE_SLEEP :
                     (state_q == MODE_STOP)    ? MODE_CODE_STOP  :
                     (state_q == MODE_STANDBY) ? MODE_CODE_STBY  :
                                                 MODE_CODE_RUN;

  wire [31:0] stat_word = {28'h0000000, stby_flag_q, pvd_out_q, mode_code};
  wire [31:0] rd_mux    = sel_ctrl ? {25'h0000000, ctrl_q}  :
                          sel_stat ? stat_word              :
                          sel_imsk ? {13'h0000, imask_q}    :
                          sel_emsk ? {13'h0000, emask_q}    :
                          sel_rise ? {13'h0000, rise_q}     :
                          sel_fall ? {13'h0000, fall_q}     :
                          sel_pend ? {13'h0000, pend_q}     :
                          sel_psel ? psel_q                 :
                                     32'h00000000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ready_q <= first;
      err_q   <= first & ~addr_ok;
      rdata_q <= first ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------
  wire wake_rise  = sync_q[SY_WAKE_PIN] & ~wake_prev_q;
  wire stby_wake  = ~sync_q[SY_PIN_N] | sync_q[SY_WATCHDOG] |
                    wake_rise | sync_q[SY_RTC];
  // standby exit resets the control, mask, edge select, port select and pending registers and sets the backup flag
  wire wipe       = (state_q == MODE_STANDBY) & stby_wake;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= sync_q[SY_WAKE_PIN];
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // registers keep their values in stop because this clock runs on
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q  <= CTRL_RST;
      imask_q <= LINE_RST;
      emask_q <= LINE_RST;
      rise_q  <= LINE_RST;
      fall_q  <= LINE_RST;
      psel_q  <= PSEL_RST;
    end else if (wipe) begin
      ctrl_q  <= CTRL_RST;
      imask_q <= LINE_RST;
      emask_q <= LINE_RST;
      rise_q  <= LINE_RST;
      fall_q  <= LINE_RST;
      psel_q  <= PSEL_RST;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_q  <= apb_i.pwdata[6:0];
      if (sel_imsk) imask_q <= wdata_lines;
      if (sel_emsk) emask_q <= wdata_lines;
      if (sel_rise) rise_q  <= wdata_lines;
      if (sel_fall) fall_q  <= wdata_lines;
      if (sel_psel) psel_q  <= apb_i.pwdata;
    end
  end

  assign pvd_en_o    = ctrl_q.pvd_en;
  assign pvd_level_o = ctrl_q.pvd_level;

  // ----------------------------------------------------------------
  // supply threshold detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pvd_out_q <= 1'b0;
    end else begin
      pvd_out_q <= sync_q[SY_SUPPLY_LOW] & ctrl_q.pvd_en;
    end
  end

  // ----------------------------------------------------------------
  // edge event controller lines
  // ----------------------------------------------------------------
  wire [NUM_LINES-1:0] line_in;
  wire [NUM_LINES-1:0] hit;

  // changing a selector may itself look like an edge on that line
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      if (gi < GPIO_LINES) begin : g_gpio
        wire [PORT_SEL_W-1:0] port_sel = psel_q[PORT_SEL_W*gi +: PORT_SEL_W];
        assign line_in[gi] = gpio_i[port_sel][gi];
      end
      lpwc_edge_det u_det (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .line_i    (line_in[gi]),
        .rise_en_i (rise_q[gi]),
        .fall_en_i (fall_q[gi]),
        .hit_o     (hit[gi])
      );
    end
  endgenerate

  // detector output on its own line gives rise, fall or both crossings
  assign line_in[LINE_SUPPLY] = pvd_out_q;
  assign line_in[LINE_RTC]    = rtc_alarm_i;
  assign line_in[LINE_SPARE]  = spare_line_i;

  // a new edge wins over a write of one in the same cycle
  wire [NUM_LINES-1:0] pend_clr = (wr_en & sel_pend) ? wdata_lines : LINE_RST;

  assign pend_d = wipe ? LINE_RST : ((pend_q & ~pend_clr) | (hit & imask_q));

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q  <= LINE_RST;
      irq_q   <= LINE_RST;
      event_q <= LINE_RST;
    end else begin
      pend_q  <= pend_d;
      irq_q   <= pend_d & imask_q;
      event_q <= hit & emask_q;
    end
  end

  assign line_irq_o   = irq_q;
  assign line_event_o = event_q;

  // ----------------------------------------------------------------
  // power mode sequencer
  // ----------------------------------------------------------------
  wire line_wake = (|(pend_q & imask_q)) | (|(hit & emask_q));

  always_comb begin
    state_d = state_q;
    case (state_q)
      MODE_RUN: begin
        if (core_sleep_req_i) begin
          if (!ctrl_q.deep_sel) begin
            state_d = MODE_SLEEP;
          end else if (ctrl_q.standby_sel) begin
            state_d = MODE_STANDBY;
          end else begin
            state_d = MODE_STOP;
          end
        end
      end
      MODE_SLEEP: begin
        if (periph_irq_i | line_wake) begin
          state_d = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (line_wake) begin
          state_d = MODE_RUN;
        end
      end
      MODE_STANDBY: begin
        if (stby_wake) begin
          state_d = MODE_RUN;
        end
      end
      default: begin
        state_d = MODE_RUN;
      end
    endcase
  end

  always_comb begin
    pwr_d = '{core_halt: 1'b0, core_clk_en: 1'b1, periph_clk_en: 1'b1,
              pll_en: 1'b1, internal_fast_rc_en: 1'b1,
              external_fast_oscillator_en: 1'b1, main_regulator_mode: 1'b1,
              low_power_regulator_mode: 1'b0, regulator_off: 1'b0,
              lowspeed_clk_en: 1'b1};
    case (state_d)
      MODE_SLEEP: begin
        pwr_d.core_halt   = 1'b1;
        pwr_d.core_clk_en = 1'b0;
      end
      MODE_STOP: begin
        pwr_d.core_halt                   = 1'b1;
        pwr_d.core_clk_en                 = 1'b0;
        pwr_d.periph_clk_en               = 1'b0;
        pwr_d.pll_en                      = 1'b0;
        pwr_d.internal_fast_rc_en         = 1'b0;
        pwr_d.external_fast_oscillator_en = 1'b0;
        pwr_d.main_regulator_mode         = ~ctrl_q.lp_reg_sel;
        pwr_d.low_power_regulator_mode    = ctrl_q.lp_reg_sel;
      end
      MODE_STANDBY: begin
        pwr_d.core_halt                   = 1'b1;
        pwr_d.core_clk_en                 = 1'b0;
        pwr_d.periph_clk_en               = 1'b0;
        pwr_d.pll_en                      = 1'b0;
        pwr_d.internal_fast_rc_en         = 1'b0;
        pwr_d.external_fast_oscillator_en = 1'b0;
        pwr_d.main_regulator_mode         = 1'b0;
        pwr_d.regulator_off               = 1'b1;
      end
      default: begin
        pwr_d.core_halt = 1'b0;
      end
    endcase
  end

  // reset values put the regulator in main mode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= MODE_RUN;
      pwr_q   <= '{core_halt: 1'b0, core_clk_en: 1'b1, periph_clk_en: 1'b1,
                   pll_en: 1'b1, internal_fast_rc_en: 1'b1,
                   external_fast_oscillator_en: 1'b1, main_regulator_mode: 1'b1,
                   low_power_regulator_mode: 1'b0, regulator_off: 1'b0,
                   lowspeed_clk_en: 1'b1};
    end else begin
      state_q <= state_d;
      pwr_q   <= pwr_d;
    end
  end

  assign pwr_o = pwr_q;

  // ----------------------------------------------------------------
  // reset hold and standby flag
  // ----------------------------------------------------------------
  wire stby_clr = wr_en & sel_stat & apb_i.pwdata[STAT_STBY_FLAG];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_reset_q <= 1'b1;
      stby_flag_q <= 1'b0;
    end else begin
      sys_reset_q <= ~sync_q[SY_SUPPLY_OK] | ~sync_q[SY_PIN_N] |
                     (state_d == MODE_STANDBY);
      stby_flag_q <= wipe | (stby_flag_q & ~stby_clr);
    end
  end

  assign sys_reset_o = sys_reset_q;
  assign apb_o       = '{prdata: rdata_q, pready: ready_q, pslverr: err_q};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sleep_core_only;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_SLEEP) |-> pwr_q.core_halt && pwr_q.periph_clk_en && pwr_q.pll_en;
  endproperty
  a_sleep_core_only: assert property (p_sleep_core_only) else $error("sleep stopped more than core");

  property p_sleep_wake;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_SLEEP) && periph_irq_i |=> (state_q == MODE_RUN) ##1 !pwr_q.core_halt;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not ended by interrupt");

  property p_stop_clocks;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_STOP) |-> !pwr_q.core_clk_en && !pwr_q.pll_en &&
      !pwr_q.internal_fast_rc_en && !pwr_q.external_fast_oscillator_en;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock left on in stop");

  property p_stop_wake;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_STOP) && (|(hit & emask_q)) |=> (state_q == MODE_RUN);
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("event did not end stop");

  property p_run_main_reg;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_RUN) |-> pwr_q.main_regulator_mode && !pwr_q.regulator_off;
  endproperty
  a_run_main_reg: assert property (p_run_main_reg) else $error("run without main regulator");

  property p_standby_off;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_STANDBY) |-> pwr_q.regulator_off && !pwr_q.pll_en && pwr_q.lowspeed_clk_en;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("standby power state wrong");

  property p_standby_hold;
    @(posedge clk_i) disable iff (reset_i)
    (state_q == MODE_STANDBY) && !stby_wake |=> (state_q == MODE_STANDBY);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby left without wake");

  property p_supply_reset;
    @(posedge clk_i) disable iff (reset_i)
    !sync_q[SY_SUPPLY_OK] |=> sys_reset_q;
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("no reset on low supply");

  property p_pvd_off;
    @(posedge clk_i) disable iff (reset_i)
    !ctrl_q.pvd_en ##1 !ctrl_q.pvd_en |-> !pvd_out_q;
  endproperty
  a_pvd_off: assert property (p_pvd_off) else $error("detector active while disabled");

  property p_pend_set;
    @(posedge clk_i) disable iff (reset_i)
    (|(hit & imask_q)) && !wipe |=> ((pend_q & $past(hit & imask_q)) == $past(hit & imask_q));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("edge lost from pending");

  property p_apb_ready;
    @(posedge clk_i) disable iff (reset_i)
    acc && !ready_q |=> ready_q ##1 !ready_q;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready timing wrong");

endmodule

`default_nettype wire

//--- test/lpwc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// core side: wait-for-interrupt pulse and peripheral irq level
// ----------------------------------------------------------------
module lpwc_core_model (
  input  wire logic clk_i,
  input  wire logic wfi_i,
  input  wire logic irq_i,
  output logic      sleep_req_o = 1'b0,
  output logic      irq_o = 1'b0
);
  // a held wfi gives a pulse on every second cycle, not one steady level
  always_ff @(posedge clk_i) begin
    sleep_req_o <= wfi_i & ~sleep_req_o;
    irq_o       <= irq_i;
  end
endmodule
`default_nettype wire

//--- test/test_low_power_mode_wakeup_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_low_power_mode_wakeup_control;
  import lpwc_pkg::*;
  logic                       clk_i, reset_i, wfi, irq_c, rtc, spare, s_ok, s_low, pin_n;
  logic                       wake, wdog, slp, pirq, sys_rst, pvd_en, err;
  logic [NUM_PORTS-1:0][15:0] gpio;
  logic [2:0]                 pvd_lvl;
  logic [NUM_LINES-1:0]       irq, evt;
  logic [31:0]                rd;
  lpwc_apb_req_t              apb_i;
  lpwc_apb_rsp_t              apb_o;
  lpwc_pwr_t                  pwr;
  int                         miscompares = 0, n_checks = 0, cycles = 0;
  lpwc_core_model core (.clk_i(clk_i), .wfi_i(wfi), .irq_i(irq_c), .sleep_req_o(slp),
    .irq_o(pirq));
  lpwc_power_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i), .apb_o(apb_o),
    .core_sleep_req_i(slp), .periph_irq_i(pirq), .gpio_i(gpio), .rtc_alarm_i(rtc),
    .spare_line_i(spare), .supply_ok_i(s_ok), .supply_below_i(s_low),
    .reset_pin_n_i(pin_n), .wake_pin_i(wake), .watchdog_reset_i(wdog), .pwr_o(pwr),
    .sys_reset_o(sys_rst), .pvd_en_o(pvd_en), .pvd_level_o(pvd_lvl), .line_irq_o(irq),
    .line_event_o(evt));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // starts one edge on, so a release never meets a new setup in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    // no wait-state count assumed: only the bench timeout ends a hung access
    do @(posedge clk_i);
    while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask
  // pulse narrower than one clock period, placed between edges
  task automatic pulse(input int p, input int b);
    @(posedge clk_i);
    #3 gpio[p][b] = 1'b1;
    #5 gpio[p][b] = 1'b0;
  endtask
  task automatic sleep_cmd();
    @(posedge clk_i);
    wfi <= 1'b1;
    @(posedge clk_i);
    wfi <= 1'b0;
    for (int i = 0; i < 12 && pwr.core_halt !== 1'b1; i++) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {wfi, irq_c, rtc, spare, s_low, wake, wdog} = '0;
    {s_ok, pin_n, reset_i} = 3'h7;
    gpio = '0;
    apb_i = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    chk(pwr, 32'h1f9);
    chk(pvd_en, 1'b0);
    for (int i = 0; i < 10 && sys_rst !== 1'b0; i++) @(posedge clk_i);
    s_ok <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(sys_rst, 1'b1);
    s_ok <= 1'b1;
    apb(1'b1, 8'h40, 32'h1);
    chk(err, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h58);
    // the write lands at the pready edge, so look one edge later
    @(posedge clk_i);
    chk({pvd_en, pvd_lvl}, 4'hd);
    $display("end of reset and register test");
    apb(1'b1, OFS_PSEL, 32'h80);
    apb(1'b1, OFS_RISE, 32'h10048);
    apb(1'b1, OFS_FALL, 32'h20);
    apb(1'b1, OFS_IMASK, 32'h10028);
    apb(1'b1, OFS_EMASK, 32'h20);
    pulse(2, 3);
    for (int i = 0; i < 8 && irq[3] !== 1'b1; i++) @(posedge clk_i);
    chk(irq, 32'h8);
    apb(1'b1, OFS_PEND, 32'h0);
    apb(1'b0, OFS_PEND, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, OFS_PEND, 32'h8);
    apb(1'b0, OFS_PEND, 32'h0);
    chk(rd, 32'h0);
    pulse(0, 5);
    pulse(0, 6);
    for (int i = 0; i < 8 && evt[5] !== 1'b1; i++) @(posedge clk_i);
    chk(evt, 32'h20);
    apb(1'b0, OFS_PEND, 32'h0);
    chk(rd, 32'h20);
    apb(1'b1, OFS_PEND, 32'h20);
    s_low <= 1'b1;
    repeat (8) @(posedge clk_i);
    apb(1'b0, OFS_PEND, 32'h0);
    chk(rd, 32'h10000);
    apb(1'b1, OFS_PEND, 32'h10000);
    $display("end of edge line test");
    apb(1'b1, OFS_CTRL, 32'h0);
    sleep_cmd();
    chk({pwr.core_halt, pwr.periph_clk_en, pwr.main_regulator_mode}, 3'h7);
    irq_c <= 1'b1;
    for (int i = 0; i < 8 && pwr.core_halt !== 1'b0; i++) @(posedge clk_i);
    chk(pwr.core_halt, 1'b0);
    irq_c <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h5);
    sleep_cmd();
    chk({pwr.core_clk_en, pwr.pll_en, pwr.internal_fast_rc_en,
      pwr.external_fast_oscillator_en, pwr.low_power_regulator_mode,
      pwr.lowspeed_clk_en}, 6'h3);
    pulse(2, 3);
    for (int i = 0; i < 10 && pwr.core_halt !== 1'b0; i++) @(posedge clk_i);
    chk(pwr.core_halt, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, OFS_PEND, 32'h8);
    $display("end of sleep and stop test");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_IMASK, 32'h8);
      apb(1'b1, OFS_CTRL, 32'h3);
      sleep_cmd();
      pulse(2, 3);
      repeat (6) @(posedge clk_i);
      chk({pwr.regulator_off, pwr.pll_en, pwr.lowspeed_clk_en}, 3'h5);
      case (k)
        0: wake <= 1'b1;
        1: wdog <= 1'b1;
        2: rtc <= 1'b1;
        default: pin_n <= 1'b0;
      endcase
      for (int i = 0; i < 10 && pwr.regulator_off !== 1'b0; i++) @(posedge clk_i);
      chk(pwr.regulator_off, 1'b0);
      {wake, wdog, rtc, pin_n} <= 4'h1;
      for (int i = 0; i < 10 && sys_rst !== 1'b0; i++) @(posedge clk_i);
      apb(1'b0, OFS_IMASK, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h8);
      apb(1'b1, OFS_STAT, 32'h8);
    end
    $display("end of standby test");
    final_report();
  end
endmodule
`default_nettype wire
